// ---- verilog/eawsc_top.sv ----
// Bus-cycle sequencer that inserts wait states for the eight external areas
module eawsc_top
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Operating mode
    input wire logic [2:0] op_mode_in,
    // Bus cycle request
    input wire logic cyc_req_in,
    input wire logic cyc_onchip_in,
    input wire logic [2:0] cyc_area_in,
    // External wait pin, active low
    input wire logic wait_n_in,
    // Cycle progress
    output logic cyc_busy_out,
    output logic [2:0] bus_state_out,
    output logic cyc_done_out
);
    logic [7:0] ast_reg;
    logic [7:0] wce_reg;
    logic [7:0] wcr_reg;
    logic [31:0] rdata;
    logic slverr;
    logic wait_n_s1;
    logic wait_n_s2;
    logic wait_n_fall;
    logic single_chip;
    eawsc_pkg::eawsc_state_t state;
    eawsc_pkg::eawsc_state_t next_state;
    eawsc_pkg::eawsc_cfg_t cfg;
    eawsc_pkg::eawsc_cfg_t next_cfg;
    logic onchip;
    logic [1:0] wcnt;
    logic [1:0] next_wcnt;
    logic pin_phase;
    logic next_pin_phase;
    logic [7:0] status;

    eawsc_apb_regs u_regs
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(rdata),
        .pslverr_out(slverr),
        .area_state_count_reg_out(ast_reg),
        .wait_ctrl_enable_reg_out(wce_reg),
        .wait_control_reg_out(wcr_reg),
        .status_in(status)
    );

    // ------------------------------------------------------------
    // APB answer: one wait in setup, ready in access phase
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            pready_out <= 1'b0;
        else
            pready_out <= psel_in && !penable_in;
    end
    assign prdata_out = rdata;
    assign pslverr_out = slverr;

    // ------------------------------------------------------------
    // Wait pin: two-stage sync, then falling-edge sample
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wait_n_s1 <= 1'b1;
            wait_n_s2 <= 1'b1;
        end
        else
        begin
            wait_n_s1 <= wait_n_in;
            wait_n_s2 <= wait_n_s1;
        end
    end

    // Falling-edge sample keeps the half-cycle setup of the pin timing
    always_ff @(negedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            wait_n_fall <= 1'b1;
        else
            wait_n_fall <= wait_n_s2;
    end

    assign single_chip = (op_mode_in == eawsc_pkg::MODE_SINGLE_6)
        || (op_mode_in == eawsc_pkg::MODE_SINGLE_7);

    // ------------------------------------------------------------
    // Settings latched at cycle start so writes act next cycle
    // ------------------------------------------------------------
    always_comb
    begin
        next_cfg = cfg;
        if (cyc_req_in && (state == eawsc_pkg::ST_IDLE || state == eawsc_pkg::ST_T3
            || (state == eawsc_pkg::ST_T2 && !cfg.three_state)))
        begin
            next_cfg.three_state = ast_reg[cyc_area_in] && !cyc_onchip_in && !single_chip;
            next_cfg.wsc_enable = wce_reg[cyc_area_in];
            next_cfg.mode = eawsc_pkg::eawsc_wmode_t'(wcr_reg[eawsc_pkg::WCR_MODE_LSB +: 2]);
            next_cfg.count = wcr_reg[eawsc_pkg::WCR_COUNT_LSB +: 2];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cfg <= '{1'b1, 1'b1, eawsc_pkg::WMODE_PROG, 2'h3};
            onchip <= 1'b0;
        end
        else
        begin
            cfg <= next_cfg;
            if (next_state == eawsc_pkg::ST_T1)
                onchip <= cyc_onchip_in;
        end
    end

    // ------------------------------------------------------------
    // State sequencer T1, T2, Tw..., T3
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_wcnt = wcnt;
        next_pin_phase = pin_phase;
        case (state)
            eawsc_pkg::ST_IDLE, eawsc_pkg::ST_T3:
            begin
                next_state = cyc_req_in ? eawsc_pkg::ST_T1 : eawsc_pkg::ST_IDLE;
            end
            eawsc_pkg::ST_T1:
                next_state = eawsc_pkg::ST_T2;
            eawsc_pkg::ST_T2:
            begin
                next_pin_phase = 1'b0;
                if (!cfg.three_state)
                    next_state = cyc_req_in ? eawsc_pkg::ST_T1 : eawsc_pkg::ST_IDLE;
                else if (!cfg.wsc_enable)
                begin
                    next_pin_phase = 1'b1;
                    next_state = wait_n_fall ? eawsc_pkg::ST_T3 : eawsc_pkg::ST_TW;
                end
                else
                begin
                    case (cfg.mode)
                        eawsc_pkg::WMODE_PROG:
                        begin
                            next_wcnt = cfg.count;
                            next_state = (cfg.count != 2'h0) ? eawsc_pkg::ST_TW : eawsc_pkg::ST_T3;
                        end
                        eawsc_pkg::WMODE_PIN1:
                        begin
                            next_wcnt = cfg.count;
                            if (cfg.count == 2'h0)
                            begin
                                next_pin_phase = 1'b1;
                                next_state = wait_n_fall ? eawsc_pkg::ST_T3 : eawsc_pkg::ST_TW;
                            end
                            else
                                next_state = eawsc_pkg::ST_TW;
                        end
                        eawsc_pkg::WMODE_AUTO:
                        begin
                            next_wcnt = cfg.count;
                            next_state = (!wait_n_fall && cfg.count != 2'h0) ?
                                eawsc_pkg::ST_TW : eawsc_pkg::ST_T3;
                        end
                        default:
                            next_state = eawsc_pkg::ST_T3;
                    endcase
                end
            end
            eawsc_pkg::ST_TW:
            begin
                if (pin_phase)
                    next_state = wait_n_fall ? eawsc_pkg::ST_T3 : eawsc_pkg::ST_TW;
                else if (wcnt > 2'h1)
                    next_wcnt = wcnt - 2'h1;
                else if (cfg.wsc_enable && cfg.mode == eawsc_pkg::WMODE_PIN1)
                begin
                    next_wcnt = 2'h0;
                    next_pin_phase = 1'b1;
                    next_state = wait_n_fall ? eawsc_pkg::ST_T3 : eawsc_pkg::ST_TW;
                end
                else
                begin
                    next_wcnt = 2'h0;
                    next_state = eawsc_pkg::ST_T3;
                end
            end
            default:
                next_state = eawsc_pkg::ST_IDLE;
        endcase
        if (state == eawsc_pkg::ST_T1 && (onchip || !cfg.three_state))
            next_state = eawsc_pkg::ST_T2;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= eawsc_pkg::ST_IDLE;
            wcnt <= 2'h0;
            pin_phase <= 1'b0;
        end
        else
        begin
            state <= next_state;
            wcnt <= next_wcnt;
            pin_phase <= next_pin_phase;
        end
    end

    // ------------------------------------------------------------
    // Registered cycle outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cyc_busy_out <= 1'b0;
            bus_state_out <= eawsc_pkg::ST_IDLE;
            cyc_done_out <= 1'b0;
        end
        else
        begin
            cyc_busy_out <= (next_state != eawsc_pkg::ST_IDLE);
            bus_state_out <= next_state;
            cyc_done_out <= (next_state == eawsc_pkg::ST_T3)
                || (state == eawsc_pkg::ST_T1 && next_state == eawsc_pkg::ST_T2 && !cfg.three_state);
        end
    end

    assign status = {single_chip, cfg.three_state, pin_phase, wcnt, state};
endmodule // eawsc_top

// ---- verilog/eawsc_pkg.sv ----
// Package of constants and carrier types for the external-area wait-state controller
package eawsc_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_AREA_STATE = 8'h00;
    localparam logic [7:0] ADDR_WAIT_EN = 8'h04;
    localparam logic [7:0] ADDR_WAIT_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] RST_AREA_STATE = 8'hFF;
    localparam logic [7:0] RST_WAIT_EN = 8'hFF;
    localparam logic [7:0] RST_WAIT_CTRL = 8'hF3;
    localparam int WCR_MODE_LSB = 2;
    localparam int WCR_COUNT_LSB = 0;
    localparam logic [7:0] WCR_WRITE_MASK = 8'h0F;
    localparam int ONCHIP_STATES = 2;
    localparam logic [2:0] MODE_SINGLE_6 = 3'h6;
    localparam logic [2:0] MODE_SINGLE_7 = 3'h7;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        WMODE_PROG = 2'b00,
        WMODE_NONE = 2'b01,
        WMODE_PIN1 = 2'b10,
        WMODE_AUTO = 2'b11
    } eawsc_wmode_t;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_T1 = 3'b001,
        ST_T2 = 3'b010,
        ST_TW = 3'b011,
        ST_T3 = 3'b100
    } eawsc_state_t;
    typedef struct packed
    {
        logic three_state;
        logic wsc_enable;
        eawsc_wmode_t mode;
        logic [1:0] count;
    } eawsc_cfg_t;
endpackage

// ---- verilog/eawsc_apb_regs.sv ----
// APB register file for the wait-state controller settings
module eawsc_apb_regs
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    // Settings and status
    output logic [7:0] area_state_count_reg_out,
    output logic [7:0] wait_ctrl_enable_reg_out,
    output logic [7:0] wait_control_reg_out,
    input wire logic [7:0] status_in
);
    logic wr;
    logic rd;
    logic hit;
    assign wr = psel_in && penable_in && pwrite_in;
    assign rd = psel_in && penable_in && !pwrite_in;
    assign hit = (paddr_in == eawsc_pkg::ADDR_AREA_STATE) || (paddr_in == eawsc_pkg::ADDR_WAIT_EN)
        || (paddr_in == eawsc_pkg::ADDR_WAIT_CTRL) || (paddr_in == eawsc_pkg::ADDR_STATUS);

    // ------------------------------------------------------------
    // Setting registers, all eight area bits written together by one access
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            area_state_count_reg_out <= eawsc_pkg::RST_AREA_STATE;
            wait_ctrl_enable_reg_out <= eawsc_pkg::RST_WAIT_EN;
            wait_control_reg_out <= eawsc_pkg::RST_WAIT_CTRL;
        end
        else if (wr)
        begin
            if (paddr_in == eawsc_pkg::ADDR_AREA_STATE)
                area_state_count_reg_out <= pwdata_in[7:0];
            if (paddr_in == eawsc_pkg::ADDR_WAIT_EN)
                wait_ctrl_enable_reg_out <= pwdata_in[7:0];
            if (paddr_in == eawsc_pkg::ADDR_WAIT_CTRL)
                // Upper nibble is unused and stays one
                wait_control_reg_out <= (pwdata_in[7:0] & eawsc_pkg::WCR_WRITE_MASK)
                    | (eawsc_pkg::RST_WAIT_CTRL & ~eawsc_pkg::WCR_WRITE_MASK);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prdata_out <= 32'h0;
            pslverr_out <= 1'b0;
        end
        else
        begin
            prdata_out <= 32'h0;
            pslverr_out <= 1'b0;
            if (psel_in && !penable_in)
            begin
                pslverr_out <= !hit;
                if (!pwrite_in)
                begin
                    case (paddr_in)
                        eawsc_pkg::ADDR_AREA_STATE: prdata_out <= {24'h0, area_state_count_reg_out};
                        eawsc_pkg::ADDR_WAIT_EN: prdata_out <= {24'h0, wait_ctrl_enable_reg_out};
                        eawsc_pkg::ADDR_WAIT_CTRL: prdata_out <= {24'h0, wait_control_reg_out};
                        eawsc_pkg::ADDR_STATUS: prdata_out <= {24'h0, status_in};
                        default: prdata_out <= 32'h0;
                    endcase
                end
            end
            else if (rd)
            begin
                prdata_out <= prdata_out;
                pslverr_out <= pslverr_out;
            end
        end
    end
endmodule // eawsc_apb_regs

// ---- test/eawsc_properties.sv ----
// Concurrent checks on the wait-state controller ports
module eawsc_properties
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [7:0] paddr_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Bus cycle
    input wire logic [2:0] op_mode_in,
    input wire logic cyc_onchip_in,
    input wire logic cyc_busy_out,
    input wire logic [2:0] bus_state_out,
    input wire logic cyc_done_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // ----
    // Sequences
    // ----
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_base;
        bus_state_out == 3'h1 ##1 (bus_state_out == 3'h2 && !cyc_done_out);
    endsequence
    // ----
    // Properties
    // ----
    a_apb_answer: assert property (s_setup |=> pready_out)
        else $error("pready not one cycle after setup");
    a_ready_single: assert property (pready_out |=> !pready_out)
        else $error("pready held past access");
    a_unmapped_err: assert property (psel_in && !penable_in && paddr_in > 8'h0C
        |=> pslverr_out && pready_out)
        else $error("no error on unmapped address");
    a_three_base: assert property (s_base |=> bus_state_out inside {3'h3, 3'h4})
        else $error("three-state cycle cut short");
    a_t1_then_t2: assert property (bus_state_out == 3'h1 |=> bus_state_out == 3'h2)
        else $error("first state not followed by second");
    a_wait_origin: assert property (bus_state_out == 3'h3
        |-> $past(bus_state_out) inside {3'h2, 3'h3})
        else $error("wait state out of place");
    a_end_done: assert property (bus_state_out == 3'h4 |-> cyc_done_out)
        else $error("done missing in last state");
    a_onchip_fixed: assert property (bus_state_out == 3'h1 && cyc_onchip_in
        |=> cyc_done_out)
        else $error("on-chip cycle not two states");
    a_single_chip: assert property (bus_state_out == 3'h1 && op_mode_in[2:1] == 2'h3
        |=> cyc_done_out)
        else $error("single-chip cycle not two states");
    a_busy_level: assert property (bus_state_out != 3'h0 |-> cyc_busy_out)
        else $error("busy low inside a cycle");
endmodule // eawsc_properties

bind eawsc_top eawsc_properties chk (.clk_in, .rst_in, .psel_in, .penable_in, .paddr_in,
    .pready_out, .pslverr_out, .op_mode_in, .cyc_onchip_in, .cyc_busy_out, .bus_state_out,
    .cyc_done_out);

// ---- test/eawsc_ext_dev.sv ----
// Model of an external device that stretches cycles with the wait pin
module eawsc_ext_dev
#(
    parameter int HOLD_LIMIT = 4
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Cycle view and bench control
    input wire logic [2:0] bus_state_in,
    input wire logic hold_in,
    // Wait pin, active low
    output logic wait_n_out
);
    logic [3:0] tw_seen;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            tw_seen <= 4'h0;
        else if (bus_state_in == 3'h1)
            tw_seen <= 4'h0;
        else if (bus_state_in == 3'h3)
            tw_seen <= tw_seen + 4'h1;
    end
    // Pulled low ahead of the cycle, since the pin is synchronised late;
    // released after a bounded stretch, and the pull-up then reads high
    assign wait_n_out = !(hold_in && tw_seen < HOLD_LIMIT);
endmodule // eawsc_ext_dev

// ---- test/eawsc_bench.sv ----
// Self-checking bench for the external-area wait-state controller
module eawsc_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic cyc_req_in, cyc_onchip_in, wait_n_in, wait_hold, cyc_busy_out, cyc_done_out, err;
    logic [2:0] op_mode_in, cyc_area_in, bus_state_out;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    eawsc_top uut (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .op_mode_in, .cyc_req_in,
        .cyc_onchip_in, .cyc_area_in, .wait_n_in, .cyc_busy_out, .bus_state_out,
        .cyc_done_out);
    eawsc_ext_dev dev (.clk_in, .rst_in, .bus_state_in(bus_state_out), .hold_in(wait_hold),
        .wait_n_out(wait_n_in));

    initial
    begin
        clk_in = 1'h0;
        forever #2 clk_in = ~clk_in;
    end

    task automatic final_report();
        $display("mismatches %0d comparisons %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("FAIL %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    // Setup then access; request held until pready is sampled high, only the timeout ends a wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'h1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'h1;
        do
        begin
            @(posedge clk_in);
        end
        while (pready_out !== 1'h1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask

    // One bus cycle; counts states and wait states seen
    task automatic tc(input logic [2:0] a, input logic oc, input logic h, input int lo,
        input int hi, input int base);
        int st;
        int w;
        st = 0;
        w = 0;
        wait_hold <= h;
        repeat (4) @(posedge clk_in);
        cyc_area_in <= a;
        cyc_onchip_in <= oc;
        cyc_req_in <= 1'h1;
        for (int k = 0; k < 40; k++)
        begin
            @(posedge clk_in);
            if (bus_state_out != 3'h0)
            begin
                st++;
                cyc_req_in <= 1'h0;
                if (bus_state_out == 3'h3)
                    w++;
            end
            if (cyc_done_out === 1'h1)
                break;
        end
        wait_hold <= 1'h0;
        chk_rng("waits", lo, hi, w);
        chk_rng("states", base + w, base + w, st);
    endtask

    initial
    begin
        rst_in = 1'h1;
        {psel_in, penable_in, pwrite_in, cyc_req_in, cyc_onchip_in, wait_hold} = 6'h00;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        op_mode_in = 3'h1;
        cyc_area_in = 3'h0;
        repeat (10) @(posedge clk_in);
        rst_in <= 1'h0;
        apb(1'h0, eawsc_pkg::ADDR_AREA_STATE, 32'h0);
        chk("area_state", 32'h000000FF, rd);
        apb(1'h0, eawsc_pkg::ADDR_WAIT_EN, 32'h0);
        chk("wait_enable", 32'h000000FF, rd);
        apb(1'h0, eawsc_pkg::ADDR_WAIT_CTRL, 32'h0);
        chk("wait_ctrl", 32'h000000F3, rd);
        apb(1'h0, eawsc_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h00000040, rd);
        apb(1'h0, 8'h10, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        tc(3'h0, 1'h0, 1'h1, 3, 3, 3);
        for (int c = 0; c < 4; c++)
        begin
            apb(1'h1, eawsc_pkg::ADDR_WAIT_CTRL, c);
            tc(3'h2, 1'h0, 1'h1, c, c, 3);
        end
        apb(1'h1, eawsc_pkg::ADDR_AREA_STATE, 32'hFE);
        tc(3'h0, 1'h0, 1'h1, 0, 0, 2);
        tc(3'h1, 1'h0, 1'h0, 3, 3, 3);
        apb(1'h1, eawsc_pkg::ADDR_AREA_STATE, 32'hFF);
        apb(1'h1, eawsc_pkg::ADDR_WAIT_EN, 32'hFD);
        tc(3'h1, 1'h0, 1'h1, 1, 8, 3);
        tc(3'h1, 1'h0, 1'h0, 0, 0, 3);
        tc(3'h0, 1'h0, 1'h1, 3, 3, 3);
        apb(1'h1, eawsc_pkg::ADDR_WAIT_EN, 32'hFF);
        apb(1'h1, eawsc_pkg::ADDR_WAIT_CTRL, 32'h5);
        tc(3'h4, 1'h0, 1'h1, 0, 0, 3);
        apb(1'h1, eawsc_pkg::ADDR_WAIT_CTRL, 32'h9);
        tc(3'h5, 1'h0, 1'h0, 1, 1, 3);
        tc(3'h5, 1'h0, 1'h1, 2, 8, 3);
        apb(1'h1, eawsc_pkg::ADDR_WAIT_CTRL, 32'h8);
        tc(3'h6, 1'h0, 1'h0, 0, 0, 3);
        tc(3'h6, 1'h0, 1'h1, 1, 8, 3);
        apb(1'h1, eawsc_pkg::ADDR_WAIT_CTRL, 32'hE);
        apb(1'h0, eawsc_pkg::ADDR_WAIT_CTRL, 32'h0);
        chk("wait_ctrl", 32'h000000FE, rd);
        tc(3'h7, 1'h0, 1'h0, 0, 0, 3);
        tc(3'h7, 1'h0, 1'h1, 2, 2, 3);
        tc(3'h7, 1'h1, 1'h1, 0, 0, 2);
        for (int m = 6; m < 8; m++)
        begin
            op_mode_in <= m;
            tc(3'h3, 1'h0, 1'h1, 0, 0, 2);
        end
        final_report();
    end
endmodule // eawsc_bench
